// File: pcs_pkg.sv
// Summary of operation
// [RULE1] Lock status bit0 shows PLL locked
// [RULE2] Control bit7 enables the PLL
// [RULE3] Control bit6 enables the bandgap
// [RULE4] Software enables bandgap no later than PLL
// [RULE5] ADC clock 204.8 kHz times field 5:4
// [RULE6] Metering clock 819.2 kHz times field 3:2
// [RULE7] CPU clock 819.2 kHz times field 1:0
// [RULE8] Doubling bit6 doubles the CPU clock
// [RULE9] Bit7 doubles again only with bit6
// [RULE10] Analog state bit7 flags crystal failure
// [RULE11] Analog state bit5 shows comparator output
// [RULE12] Analog state bits 4:2 read five
// [RULE13] Lock clears when PLL off; 11 means x1 (code applies this to ADC and metering only; CPU field 11 gives shift 3)
package pcs_pkg;
    // Byte addresses on APB; the printed offsets are not all multiples of four
    localparam logic [15:0] IDX_LOCK    = 16'h00A3;
    localparam logic [15:0] IDX_CTRL    = 16'h2867;
    localparam logic [15:0] IDX_DOUBLE  = 16'h2868;
    localparam logic [15:0] IDX_ANALOG  = 16'h286B;
    localparam logic [15:0] IDX_IRQ_ST  = 16'h2870;
    localparam logic [15:0] IDX_IRQ_MSK = 16'h2871;
    localparam logic [17:0] ADDR_LOCK    = {IDX_LOCK, 2'b00};
    localparam logic [17:0] ADDR_CTRL    = {IDX_CTRL, 2'b00};
    localparam logic [17:0] ADDR_DOUBLE  = {IDX_DOUBLE, 2'b00};
    localparam logic [17:0] ADDR_ANALOG  = {IDX_ANALOG, 2'b00};
    localparam logic [17:0] ADDR_IRQ_ST  = {IDX_IRQ_ST, 2'b00};
    localparam logic [17:0] ADDR_IRQ_MSK = {IDX_IRQ_MSK, 2'b00};
    // Field positions
    localparam int CTRL_PLL_ON   = 7;
    localparam int CTRL_BG_ON    = 6;
    localparam int CTRL_ADC_LSB  = 4;
    localparam int CTRL_MET_LSB  = 2;
    localparam int CTRL_CPU_LSB  = 0;
    localparam int DBL_AGAIN     = 7;
    localparam int DBL_ONCE      = 6;
    localparam int AN_XTAL_FAIL  = 7;
    localparam int AN_COMP       = 5;
    localparam int AN_FIXED_LSB  = 2;
    localparam logic [2:0] AN_FIXED_VAL = 3'h5;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] DOUBLE_RST = 8'h00;
    localparam logic [7:0] DOUBLE_WMASK = 8'hC0;
    // Interrupt status bits
    localparam int IRQ_LOCK_RISE = 0;
    localparam int IRQ_LOCK_FALL = 1;
    localparam int IRQ_XTAL_FAIL = 2;
    localparam int IRQ_COMP_CHG  = 3;
    localparam int IRQ_N         = 4;
    // Base rates in hertz-tenths for exact integers
    localparam int ADC_BASE_DHZ = 2048000;
    localparam int MET_BASE_DHZ = 8192000;
    localparam int CPU_BASE_DHZ = 8192000;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [31:0] APB_BAD_DATA = 32'h0000_0000;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } pcs_apb_req_s;

    typedef struct packed {
        logic [3:0] cpu_shift;
        logic [1:0] adc_shift;
        logic [1:0] met_shift;
    } pcs_rates_s;
endpackage

// File: pcs_mult.sv
// Decodes the multiplier fields into shift amounts (log2 of the factor)
module pcs_mult (
    input  wire logic [7:0]        i_ctrl,
    input  wire logic [7:0]        i_double,
    output pcs_pkg::pcs_rates_s    o_rates
);
    // Undefined 11 falls back to x1 rather than an unknown rate
    function automatic logic [1:0] field_shift(input logic [1:0] f);
        field_shift = (f == 2'h3) ? 2'h0 : f; // [RULE13]
    endfunction

    logic [1:0] cpu_f;
    logic [3:0] dbl;

    // Doubling bits add to the CPU shift; the second needs the first
    always_comb begin
        cpu_f = i_ctrl[pcs_pkg::CTRL_CPU_LSB +: 2];                     // [RULE7]
        dbl = {3'h0, i_double[pcs_pkg::DBL_ONCE]}                        // [RULE8]
            + {3'h0, i_double[pcs_pkg::DBL_ONCE] & i_double[pcs_pkg::DBL_AGAIN]}; // [RULE9]
        o_rates.cpu_shift = {2'h0, cpu_f} + dbl;
        o_rates.adc_shift = field_shift(i_ctrl[pcs_pkg::CTRL_ADC_LSB +: 2]); // [RULE5]
        o_rates.met_shift = field_shift(i_ctrl[pcs_pkg::CTRL_MET_LSB +: 2]); // [RULE6]
    end
endmodule

// File: pcs_clock_status.sv
// Clock control and status with APB register access and one interrupt
module pcs_clock_status (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [31:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_pll_locked,
    input  wire logic        i_xtal_failed,
    input  wire logic        i_comparator_b_output,
    output logic             o_pll_power_on,
    output logic             o_bandgap_power_on,
    output logic [1:0]       o_adc_clock_shift,
    output logic [1:0]       o_metering_clock_shift,
    output logic [3:0]       o_cpu_clock_shift,
    output logic             o_irq
);
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  dbl;
        logic        lock;
        logic        xtal_fail;
        logic        comp;
        logic [pcs_pkg::IRQ_N-1:0] irq_st;
        logic [pcs_pkg::IRQ_N-1:0] irq_msk;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        pcs_pkg::pcs_rates_s rates;
    } pcs_state_s;

    pcs_state_s st;
    pcs_state_s next_st;
    pcs_pkg::pcs_rates_s rates_c;
    logic [pcs_pkg::IRQ_N-1:0] ev;
    logic acc;
    logic lock_c;

    // Rate decode is pure logic; registered here so outputs come from flops
    pcs_mult u_mult (
        .i_ctrl   (next_st.ctrl),
        .i_double (next_st.dbl),
        .o_rates  (rates_c)
    );

    function automatic logic known_addr(input logic [31:0] a);
        known_addr = (a[17:0] == pcs_pkg::ADDR_LOCK) || (a[17:0] == pcs_pkg::ADDR_CTRL)
                  || (a[17:0] == pcs_pkg::ADDR_DOUBLE) || (a[17:0] == pcs_pkg::ADDR_ANALOG)
                  || (a[17:0] == pcs_pkg::ADDR_IRQ_ST) || (a[17:0] == pcs_pkg::ADDR_IRQ_MSK);
    endfunction

    // Register next state, bus answer and event capture
    always_comb begin
        next_st = st;
        acc = i_psel && i_penable && !st.pready;
        next_st.xtal_fail = i_xtal_failed;                      // [RULE10]
        next_st.comp = i_comparator_b_output;                   // [RULE11]
        ev = '0;
        ev[pcs_pkg::IRQ_XTAL_FAIL] = i_xtal_failed && !st.xtal_fail;
        ev[pcs_pkg::IRQ_COMP_CHG]  = i_comparator_b_output != st.comp;
        next_st.pready = acc;
        next_st.pslverr = acc && !known_addr(i_paddr);
        next_st.prdata = st.prdata;
        if (acc && !i_pwrite) begin
            next_st.prdata = 32'h0000_0000;
            unique case (i_paddr[17:0])
                pcs_pkg::ADDR_LOCK:    next_st.prdata[0] = st.lock; // [RULE1]
                pcs_pkg::ADDR_CTRL:    next_st.prdata[7:0] = st.ctrl;
                pcs_pkg::ADDR_DOUBLE:  next_st.prdata[7:0] = st.dbl;
                pcs_pkg::ADDR_ANALOG: begin
                    next_st.prdata[pcs_pkg::AN_XTAL_FAIL] = st.xtal_fail; // [RULE10]
                    next_st.prdata[pcs_pkg::AN_COMP] = st.comp;           // [RULE11]
                    next_st.prdata[pcs_pkg::AN_FIXED_LSB +: 3] = pcs_pkg::AN_FIXED_VAL; // [RULE12]
                end
                pcs_pkg::ADDR_IRQ_ST:  next_st.prdata[pcs_pkg::IRQ_N-1:0] = st.irq_st;
                pcs_pkg::ADDR_IRQ_MSK: next_st.prdata[pcs_pkg::IRQ_N-1:0] = st.irq_msk;
                default:               next_st.prdata = pcs_pkg::APB_BAD_DATA;
            endcase
        end
        // Writes land only in byte lane 0, where all fields live
        if (acc && i_pwrite && i_pstrb[0]) begin
            unique case (i_paddr[17:0])
                pcs_pkg::ADDR_CTRL:    next_st.ctrl = i_pwdata[7:0]; // [RULE2] [RULE3]
                pcs_pkg::ADDR_DOUBLE:  next_st.dbl = i_pwdata[7:0] & pcs_pkg::DOUBLE_WMASK;
                pcs_pkg::ADDR_IRQ_ST:  next_st.irq_st = st.irq_st & ~i_pwdata[pcs_pkg::IRQ_N-1:0];
                pcs_pkg::ADDR_IRQ_MSK: next_st.irq_msk = i_pwdata[pcs_pkg::IRQ_N-1:0];
                default:               next_st.irq_msk = next_st.irq_msk;
            endcase
        end
        // Lock follows the enable as written this cycle, so turning the PLL off never shows a stale lock
        lock_c = i_pll_locked && next_st.ctrl[pcs_pkg::CTRL_PLL_ON]; // [RULE13]
        next_st.lock = lock_c;                                       // [RULE1]
        ev[pcs_pkg::IRQ_LOCK_RISE] = lock_c && !st.lock;
        ev[pcs_pkg::IRQ_LOCK_FALL] = !lock_c && st.lock;
        // Set wins over a same-cycle write-one clear
        next_st.irq_st = next_st.irq_st | ev;
        next_st.irq = |(next_st.irq_st & next_st.irq_msk);
        next_st.rates = rates_c; // [RULE5] [RULE6] [RULE7]
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '0;
            st.ctrl <= pcs_pkg::CTRL_RST;
            st.dbl <= pcs_pkg::DOUBLE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign o_prdata = st.prdata;
    assign o_pready = st.pready;
    assign o_pslverr = st.pslverr;
    assign o_pll_power_on = st.ctrl[pcs_pkg::CTRL_PLL_ON];     // [RULE2]
    assign o_bandgap_power_on = st.ctrl[pcs_pkg::CTRL_BG_ON];  // [RULE3]
    assign o_adc_clock_shift = st.rates.adc_shift;
    assign o_metering_clock_shift = st.rates.met_shift;
    assign o_cpu_clock_shift = st.rates.cpu_shift;
    assign o_irq = st.irq;

    AST_LOCK_NEEDS_PLL: assert property (@(posedge i_clk) disable iff (i_rst)
        st.lock |-> o_pll_power_on) else $error("lock shown with PLL off"); // [RULE13]
    AST_LOCK_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1 |=> st.lock == ($past(i_pll_locked) && o_pll_power_on)) else $error("lock not shown"); // [RULE1]
    AST_PLL_BIT: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_psel && i_penable && !o_pready && i_pwrite && i_pstrb[0] && i_paddr[17:0] == pcs_pkg::ADDR_CTRL)
        |=> o_pll_power_on == $past(i_pwdata[7]) && o_bandgap_power_on == $past(i_pwdata[6]))
        else $error("enable bits not stored"); // [RULE2]
    AST_ADC_RATE: assert property (@(posedge i_clk) disable iff (i_rst)
        o_adc_clock_shift == ((st.ctrl[5:4] == 2'h3) ? 2'h0 : st.ctrl[5:4]))
        else $error("adc multiplier wrong"); // [RULE5]
    AST_MET_RATE: assert property (@(posedge i_clk) disable iff (i_rst)
        o_metering_clock_shift == ((st.ctrl[3:2] == 2'h3) ? 2'h0 : st.ctrl[3:2]))
        else $error("metering multiplier wrong"); // [RULE6]
    AST_CPU_RATE: assert property (@(posedge i_clk) disable iff (i_rst)
        !st.dbl[6] |-> o_cpu_clock_shift == {2'h0, st.ctrl[1:0]}) else $error("cpu multiplier wrong"); // [RULE7]
    AST_CPU_DOUBLE: assert property (@(posedge i_clk) disable iff (i_rst)
        st.dbl[6] |-> o_cpu_clock_shift == {2'h0, st.ctrl[1:0]} + 4'h1 + {3'h0, st.dbl[7]})
        else $error("cpu doubling wrong"); // [RULE8] [RULE9]
    AST_ANALOG_READ: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_psel && i_penable && !o_pready && !i_pwrite && i_paddr[17:0] == pcs_pkg::ADDR_ANALOG)
        |=> o_prdata[4:2] == 3'h5 && o_prdata[7] == $past(st.xtal_fail) && o_prdata[5] == $past(st.comp))
        else $error("analog state read wrong"); // [RULE10] [RULE11] [RULE12]
endmodule

// File: pcs_testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, err;
    logic        i_pll_locked, i_xtal_failed, i_comparator_b_output, o_pll_power_on, o_bandgap_power_on, o_irq;
    logic [31:0] i_paddr, i_pwdata, o_prdata, rd, seed, r;
    logic [3:0]  i_pstrb, o_cpu_clock_shift;
    logic [1:0]  o_adc_clock_shift, o_metering_clock_shift;
    logic [7:0]  c, d;
    int          mismatches, tests_run;

    pcs_clock_status dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pll_locked(i_pll_locked), .i_xtal_failed(i_xtal_failed),
        .i_comparator_b_output(i_comparator_b_output), .o_pll_power_on(o_pll_power_on),
        .o_bandgap_power_on(o_bandgap_power_on), .o_adc_clock_shift(o_adc_clock_shift),
        .o_metering_clock_shift(o_metering_clock_shift), .o_cpu_clock_shift(o_cpu_clock_shift), .o_irq(o_irq));

    // Free-running 100 MHz clock
    initial begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end

    // Repeatable pseudo-random source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected {pll, bandgap, adc, metering, cpu} shift outputs; code 11 of adc/metering means x1
    function automatic logic [31:0] exp_out(input logic [7:0] cv, input logic [7:0] dv);
        logic [1:0] a;
        logic [1:0] m;
        a = (cv[5:4] == 2'h3) ? 2'h0 : cv[5:4];
        m = (cv[3:2] == 2'h3) ? 2'h0 : cv[3:2];
        return {22'h0, cv[7], cv[6], a, m, 2'h0, cv[1:0]} + {31'h0, dv[6]} + {31'h0, dv[6] & dv[7]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t value mismatch got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] wd, input logic [3:0] st);
        @(posedge i_clk);
        i_psel <= 1'h1;
        i_pwrite <= wr;
        i_paddr <= {14'h0, a};
        i_pwdata <= {24'h0, wd};
        i_pstrb <= st;
        @(posedge i_clk);
        i_penable <= 1'h1;
        // Outputs read right at the edge are the values sampled there; only the watchdog ends a hang
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'h1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog: the sequence needs a few thousand cycles at most
    initial begin
        #300000;
        mismatches++;
        give_verdict();
    end

    initial begin
        seed = 32'h3136;
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_pstrb} = '0;
        {i_pll_locked, i_xtal_failed, i_comparator_b_output} = 3'h0;
        mismatches = 0;
        tests_run = 0;
        i_rst = 1'h1;
        repeat (10) @(posedge i_clk);
        i_rst <= 1'h0;
        // Reset values
        apb(1'h0, pcs_pkg::ADDR_LOCK, 8'h00, 4'hF); chk(rd, 32'h0);
        apb(1'h0, pcs_pkg::ADDR_CTRL, 8'h00, 4'hF); chk(rd, 32'h0);
        apb(1'h0, pcs_pkg::ADDR_DOUBLE, 8'h00, 4'hF); chk(rd, 32'h0);
        apb(1'h0, pcs_pkg::ADDR_ANALOG, 8'h00, 4'hF); chk(rd, 32'h14);
        // Random settings, first four loops walk every field code
        for (int k = 0; k < 40; k++) begin
            c = 8'(xs());
            d = 8'(xs());
            r = xs();
            if (k < 4) c = {2'h3, k[1:0], k[1:0], k[1:0]};
            if (k < 4) d = {k[1:0], 6'h0};
            if (c[7]) c[6] = 1'h1;
            i_pll_locked <= r[0];
            i_xtal_failed <= r[1];
            i_comparator_b_output <= r[2];
            apb(1'h1, pcs_pkg::ADDR_CTRL, c, 4'h1);
            apb(1'h1, pcs_pkg::ADDR_DOUBLE, d, 4'h1);
            repeat (2) @(posedge i_clk);
            chk({22'h0, o_pll_power_on, o_bandgap_power_on, o_adc_clock_shift, o_metering_clock_shift,
                 o_cpu_clock_shift}, exp_out(c, d));
            apb(1'h0, pcs_pkg::ADDR_CTRL, 8'h00, 4'hF); chk(rd, {24'h0, c});
            apb(1'h0, pcs_pkg::ADDR_DOUBLE, 8'h00, 4'hF); chk(rd, {24'h0, d & 8'hC0});
            apb(1'h0, pcs_pkg::ADDR_ANALOG, 8'h00, 4'hF);
            chk(rd, {24'h0, r[1], 1'h0, r[2], 3'h5, 2'h0});
            apb(1'h0, pcs_pkg::ADDR_LOCK, 8'h00, 4'hF); chk(rd, {31'h0, r[0] & c[7]});
        end
        // Write with no byte strobe is ignored; unmapped address is refused
        apb(1'h1, pcs_pkg::ADDR_CTRL, ~c, 4'h0);
        apb(1'h0, pcs_pkg::ADDR_CTRL, 8'h00, 4'hF); chk(rd, {24'h0, c});
        apb(1'h0, 18'h00004, 8'h00, 4'hF); chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // Interrupt: lock rise sets status, mask gates the line, write one clears
        {i_pll_locked, i_xtal_failed, i_comparator_b_output} <= 3'h0;
        apb(1'h1, pcs_pkg::ADDR_CTRL, 8'h40, 4'h1);
        apb(1'h1, pcs_pkg::ADDR_IRQ_MSK, 8'h00, 4'h1);
        apb(1'h1, pcs_pkg::ADDR_IRQ_ST, 8'h0F, 4'h1);
        i_pll_locked <= 1'h1;
        apb(1'h1, pcs_pkg::ADDR_CTRL, 8'hC0, 4'h1);
        repeat (3) @(posedge i_clk);
        apb(1'h0, pcs_pkg::ADDR_IRQ_ST, 8'h00, 4'hF); chk(rd, 32'h1);
        chk({31'h0, o_irq}, 32'h0);
        apb(1'h1, pcs_pkg::ADDR_IRQ_MSK, 8'h0F, 4'h1);
        repeat (2) @(posedge i_clk);
        chk({31'h0, o_irq}, 32'h1);
        apb(1'h1, pcs_pkg::ADDR_IRQ_ST, 8'h01, 4'h1);
        repeat (2) @(posedge i_clk);
        chk({31'h0, o_irq}, 32'h0);
        apb(1'h0, pcs_pkg::ADDR_IRQ_ST, 8'h00, 4'hF); chk(rd, 32'h0);
        // Crystal failure, comparator change and lock fall each set their own status bit
        i_xtal_failed <= 1'h1;
        i_comparator_b_output <= 1'h1;
        apb(1'h1, pcs_pkg::ADDR_CTRL, 8'h40, 4'h1);
        apb(1'h0, pcs_pkg::ADDR_IRQ_ST, 8'h00, 4'hF); chk(rd, 32'hE);
        chk({31'h0, o_irq}, 32'h1);
        apb(1'h0, pcs_pkg::ADDR_LOCK, 8'h00, 4'hF); chk(rd, 32'h0);
        apb(1'h1, pcs_pkg::ADDR_IRQ_ST, 8'h0F, 4'h1);
        apb(1'h0, pcs_pkg::ADDR_IRQ_ST, 8'h00, 4'hF); chk(rd, 32'h0);
        give_verdict();
    end
endmodule
